// >>> design/jtag_tap_defines.vh
// constants for the test access port and debug pin block
`ifndef JTAG_TAP_DEFINES_VH
`define JTAG_TAP_DEFINES_VH

// instruction codes
`define IR_W 4
`define IR_EXTEST 4'h0
`define IR_INTEST 4'h1
`define IR_SAMPLE 4'h2
`define IR_ABORT 4'h8
`define IR_DPACC 4'ha
`define IR_APACC 4'hb
`define IR_IDCODE 4'he
`define IR_BYPASS 4'hf
`define IR_CAPTURE 4'h1

// debug access chain layout
`define DBG_W 35
`define ACK_W 3
`define ACK_OK 3'h2
`define ACK_WAIT 3'h1

// chain selection
`define SEL_BYP 2'h0
`define SEL_ID 2'h1
`define SEL_DBG 2'h2

// mode switch sequences
`define SW_TO_SWD 16'he79e
`define SW_TO_JTAG 16'he73c
`define SW_RUN_MIN 6'h32
`define SW_BITS 5'h10
`define RECOV_COUNT 4'ha

// register offsets
`define OFF_AFSEL 8'h00
`define OFF_DEN 8'h04
`define OFF_PUR 8'h08
`define OFF_LOCK 8'h0c
`define OFF_COMMIT 8'h10
`define OFF_STATUS 8'h14

// debug pin reset values and lock key
`define PIN_N 5
`define PIN_RST 5'h1f
`define LOCK_KEY 32'h1acce551

`endif

// >>> design/pin_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pin_sync #(
	parameter W = 5,
	parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// data
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_r;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// >>> design/jtag_tap_debug_port.v
// test access port with debug chain, mode switch detect and debug pin control
// Functional notes
// - test logic advances only on edges of the test clock, not on system events
// - a stopped test clock changes no state and loses no register content
// - mode select is sampled on test clock rise to pick the next state
// - five high mode select clocks reach test-logic-reset from any state
// - entering test-logic-reset loads the identity instruction
// - data in is sampled on rise and fed to the selected chain
// - data out comes from instruction chain or selected data chain
// - data out is not driven unless shifting
// - data out changes on test clock fall
// - power-on reset or test reset forces test-logic-reset
// - capture loads the chain, shift moves out and in at once
// - update moves shifted chain content into its parallel register
// - system reset returns the five debug pins to the debug function
// - protected function select bits change only when unlocked and committed
// - ten alternating switches under system reset request a mass erase
// - recovery erase ignores flash protection, keeps nonvolatile settings
// - debug capture returns previous result with a three bit acknowledge
// - test reset is active low and holds test-logic-reset while low
// - switch to serial wire: 50 high, pattern e79e lsb first, 50 high
// - switch to jtag: 50 high, pattern e73c lsb first, 5 high
// - the instruction register is four bits with a parallel stage
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "jtag_tap_defines.vh"
module jtag_tap_debug_port #(
	parameter [31:0] IDCODE_VALUE = 32'h00000001, // arbitrary identity value
	parameter AW = 8
) (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// test port pins
	input wire tck,
	input wire tms,
	input wire tdi,
	input wire trst_n,
	output reg tdo,
	output reg tdo_oe,
	// system reset pin
	input wire sys_rst_n,
	// register port
	input wire [AW-1:0] addr,
	input wire [31:0] wdata,
	input wire wr,
	input wire rd,
	output reg [31:0] rdata,
	// debug access to the system
	output reg dbg_req,
	output reg dbg_ap,
	output reg dbg_rnw,
	output reg [1:0] dbg_addr,
	output reg [31:0] dbg_wdata,
	input wire dbg_done,
	input wire [31:0] dbg_rdata,
	// debug pin configuration
	output reg [`PIN_N-1:0] pin_alt_function_select,
	output reg [`PIN_N-1:0] pin_digital_enable,
	output reg [`PIN_N-1:0] pin_pullup_enable,
	// mode and recovery
	output reg swd_mode,
	output reg flash_mass_erase,
	output reg [`IR_W-1:0] cur_instr
);
	localparam [3:0] S_TLR = 4'h0;
	localparam [3:0] S_RTI = 4'h1;
	localparam [3:0] S_SDS = 4'h2;
	localparam [3:0] S_CDR = 4'h3;
	localparam [3:0] S_SHD = 4'h4;
	localparam [3:0] S_E1D = 4'h5;
	localparam [3:0] S_PDR = 4'h6;
	localparam [3:0] S_E2D = 4'h7;
	localparam [3:0] S_UDR = 4'h8;
	localparam [3:0] S_SIS = 4'h9;
	localparam [3:0] S_CIR = 4'ha;
	localparam [3:0] S_SHI = 4'hb;
	localparam [3:0] S_E1I = 4'hc;
	localparam [3:0] S_PIR = 4'hd;
	localparam [3:0] S_E2I = 4'he;
	localparam [3:0] S_UIR = 4'hf;

	// next tap state from state and sampled mode select
	function [3:0] tap_next;
		input [3:0] s;
		input m;
		begin
			case (s)
				S_TLR: tap_next = m ? S_TLR : S_RTI;
				S_RTI: tap_next = m ? S_SDS : S_RTI;
				S_SDS: tap_next = m ? S_SIS : S_CDR;
				S_CDR: tap_next = m ? S_E1D : S_SHD;
				S_SHD: tap_next = m ? S_E1D : S_SHD;
				S_E1D: tap_next = m ? S_UDR : S_PDR;
				S_PDR: tap_next = m ? S_E2D : S_PDR;
				S_E2D: tap_next = m ? S_UDR : S_SHD;
				S_UDR: tap_next = m ? S_SDS : S_RTI;
				S_SIS: tap_next = m ? S_TLR : S_CIR;
				S_CIR: tap_next = m ? S_E1I : S_SHI;
				S_SHI: tap_next = m ? S_E1I : S_SHI;
				S_E1I: tap_next = m ? S_UIR : S_PIR;
				S_PIR: tap_next = m ? S_E2I : S_PIR;
				S_E2I: tap_next = m ? S_UIR : S_SHI;
				S_UIR: tap_next = m ? S_SDS : S_RTI;
				default: tap_next = S_TLR;
			endcase
		end
	endfunction

	// data chain chosen by the instruction
	function [1:0] dr_sel;
		input [3:0] ir;
		begin
			case (ir)
				`IR_IDCODE: dr_sel = `SEL_ID;
				`IR_DPACC: dr_sel = `SEL_DBG;
				`IR_APACC: dr_sel = `SEL_DBG;
				`IR_ABORT: dr_sel = `SEL_DBG;
				default: dr_sel = `SEL_BYP;
			endcase
		end
	endfunction

	// pin synchronisers
	wire [4:0] sync_q;
	pin_sync #(.W(5), .RST_VAL(5'h1f)) u_sync (
		.clk(clk),
		.arst_n(arst_n),
		.d({sys_rst_n, trst_n, tdi, tms, tck}),
		.q(sync_q)
	);
	wire tck_s = sync_q[0];
	wire tms_s = sync_q[1];
	wire tdi_s = sync_q[2];
	wire trst_s = sync_q[3];
	wire sysrst_s = sync_q[4];

	reg tck_d_r;
	wire tck_rise = tck_s & ~tck_d_r;
	wire tck_fall = ~tck_s & tck_d_r;

	reg [3:0] state_r;
	reg [3:0] ir_sh_r;
	reg bp_r;
	reg [31:0] id_sh_r;
	reg [`DBG_W-1:0] dbg_sh_r;
	reg busy_r;
	reg [31:0] result_r;
	wire [1:0] sel = dr_sel(cur_instr);
	wire [3:0] st_nxt = tap_next(state_r, tms_s);
	wire [`ACK_W-1:0] ack = busy_r ? `ACK_WAIT : `ACK_OK;

	// selected serial output bit
	reg chain_bit;
	always @* begin
		chain_bit = bp_r;
		if (state_r == S_SHI) begin
			chain_bit = ir_sh_r[0];
		end else if (sel == `SEL_ID) begin
			chain_bit = id_sh_r[0];
		end else if (sel == `SEL_DBG) begin
			chain_bit = dbg_sh_r[0];
		end
	end

	// tap state machine and chains, moved by test clock edges and forced to test-logic-reset by test reset
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tck_d_r <= 1'b1;
			state_r <= S_TLR;
			cur_instr <= `IR_IDCODE;
			ir_sh_r <= `IR_CAPTURE;
			bp_r <= 1'b0;
			id_sh_r <= 32'h00000000;
			dbg_sh_r <= {`DBG_W{1'b0}};
			tdo <= 1'b0;
			tdo_oe <= 1'b0;
		end else begin
			tck_d_r <= tck_s;
			if (!trst_s) begin
				state_r <= S_TLR;
				cur_instr <= `IR_IDCODE;
				tdo_oe <= 1'b0;
			end else if (tck_rise) begin
				state_r <= st_nxt;
				if (st_nxt == S_TLR) begin
					cur_instr <= `IR_IDCODE;
				end
				case (state_r)
					S_CIR: ir_sh_r <= `IR_CAPTURE;
					S_SHI: ir_sh_r <= {tdi_s, ir_sh_r[3:1]};
					S_UIR: cur_instr <= ir_sh_r;
					S_CDR: begin
						bp_r <= 1'b0;
						id_sh_r <= IDCODE_VALUE;
						dbg_sh_r <= {result_r, ack};
					end
					S_SHD: begin
						case (sel)
							`SEL_ID: id_sh_r <= {tdi_s, id_sh_r[31:1]};
							`SEL_DBG: dbg_sh_r <= {tdi_s, dbg_sh_r[`DBG_W-1:1]};
							default: bp_r <= tdi_s;
						endcase
					end
					default: ir_sh_r <= ir_sh_r;
				endcase
			end else if (tck_fall) begin
				// output follows falling edge, idle when not shifting
				tdo <= chain_bit;
				tdo_oe <= ~swd_mode & ((state_r == S_SHI) | (state_r == S_SHD));
			end
		end
	end

	// debug transaction launched from the update state
	wire upd_dbg = tck_rise & trst_s & (state_r == S_UDR) & (sel == `SEL_DBG);
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy_r <= 1'b0;
			result_r <= 32'h00000000;
			dbg_req <= 1'b0;
			dbg_ap <= 1'b0;
			dbg_rnw <= 1'b0;
			dbg_addr <= 2'h0;
			dbg_wdata <= 32'h00000000;
		end else begin
			if (upd_dbg && cur_instr == `IR_ABORT) begin
				busy_r <= 1'b0;
				dbg_req <= 1'b0;
			end else if (upd_dbg && !busy_r) begin
				busy_r <= 1'b1;
				dbg_req <= 1'b1;
				dbg_ap <= (cur_instr == `IR_APACC);
				dbg_rnw <= dbg_sh_r[0];
				dbg_addr <= dbg_sh_r[2:1];
				dbg_wdata <= dbg_sh_r[`DBG_W-1:`ACK_W];
			end else if (busy_r && dbg_done) begin
				busy_r <= 1'b0;
				dbg_req <= 1'b0;
				result_r <= dbg_rdata;
			end
		end
	end

	// switch sequence detection on the mode select line
	reg [5:0] run_r;
	reg [4:0] seq_cnt_r;
	reg [15:0] seq_sh_r;
	reg [3:0] recov_r;
	wire [15:0] seq_nxt = {tms_s, seq_sh_r[15:1]};
	wire seq_end = tck_rise & (seq_cnt_r == `SW_BITS - 5'h01);
	wire to_swd = seq_end & (seq_nxt == `SW_TO_SWD);
	wire to_jtag = seq_end & (seq_nxt == `SW_TO_JTAG);
	wire want_swd = ~recov_r[0];
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_r <= 6'h00;
			seq_cnt_r <= 5'h00;
			seq_sh_r <= 16'h0000;
			swd_mode <= 1'b0;
			recov_r <= 4'h0;
			flash_mass_erase <= 1'b0;
		end else begin
			flash_mass_erase <= 1'b0;
			if (tck_rise) begin
				if (!tms_s) begin
					run_r <= 6'h00;
				end else if (run_r != `SW_RUN_MIN) begin
					run_r <= run_r + 6'h01;
				end
				if (seq_cnt_r != 5'h00) begin
					seq_sh_r <= seq_nxt;
					seq_cnt_r <= seq_end ? 5'h00 : seq_cnt_r + 5'h01;
				end else if (!tms_s && run_r == `SW_RUN_MIN) begin
					seq_sh_r <= seq_nxt;
					seq_cnt_r <= 5'h01;
				end
			end
			if (to_swd) begin
				swd_mode <= 1'b1;
			end else if (to_jtag) begin
				swd_mode <= 1'b0;
			end
			// recovery counts alternating switches only while system reset is held
			if (sysrst_s) begin
				recov_r <= 4'h0;
			end else if ((to_swd && want_swd) || (to_jtag && !want_swd)) begin
				if (recov_r == `RECOV_COUNT - 4'h1) begin
					recov_r <= 4'h0;
					flash_mass_erase <= 1'b1;
				end else begin
					recov_r <= recov_r + 4'h1;
				end
			end else if (to_swd) begin
				recov_r <= 4'h1;
			end else if (to_jtag) begin
				recov_r <= 4'h0;
			end
		end
	end

	// debug pin configuration registers
	reg unlocked_r;
	reg [`PIN_N-1:0] commit_r;
	wire wr_afsel = wr & (addr == `OFF_AFSEL);
	wire wr_lock = wr & (addr == `OFF_LOCK);
	wire wr_commit = wr & (addr == `OFF_COMMIT);
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pin_alt_function_select <= `PIN_RST;
			pin_digital_enable <= `PIN_RST;
			pin_pullup_enable <= `PIN_RST;
			unlocked_r <= 1'b0;
			commit_r <= {`PIN_N{1'b0}};
		end else if (!sysrst_s) begin
			pin_alt_function_select <= `PIN_RST;
			pin_digital_enable <= `PIN_RST;
			pin_pullup_enable <= `PIN_RST;
			unlocked_r <= 1'b0;
			commit_r <= {`PIN_N{1'b0}};
		end else begin
			if (wr_lock) begin
				unlocked_r <= (wdata == `LOCK_KEY);
			end
			if (wr_commit && unlocked_r) begin
				commit_r <= wdata[`PIN_N-1:0];
			end
			if (wr_afsel && unlocked_r) begin
				pin_alt_function_select <= (commit_r & wdata[`PIN_N-1:0]) |
					(~commit_r & pin_alt_function_select);
			end
			if (wr && addr == `OFF_DEN) begin
				pin_digital_enable <= wdata[`PIN_N-1:0];
			end
			if (wr && addr == `OFF_PUR) begin
				pin_pullup_enable <= wdata[`PIN_N-1:0];
			end
		end
	end

	// read data, one cycle after the strobe
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			case (addr)
				`OFF_AFSEL: rdata <= {27'h0, pin_alt_function_select};
				`OFF_DEN: rdata <= {27'h0, pin_digital_enable};
				`OFF_PUR: rdata <= {27'h0, pin_pullup_enable};
				`OFF_LOCK: rdata <= {31'h0, ~unlocked_r};
				`OFF_COMMIT: rdata <= {27'h0, commit_r};
				`OFF_STATUS: rdata <= {16'h0, recov_r, busy_r, swd_mode, 2'h0, state_r, cur_instr};
				default: rdata <= 32'h00000000;
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end
endmodule

// >>> verification/jtag_tap_debug_port_asserts.sv
// concurrent checks on the test access port block
`timescale 1ns/1ns
module jtag_tap_debug_port_asserts #(
	parameter AW = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// pins
	input wire logic tck,
	input wire logic trst_n,
	input wire logic sys_rst_n,
	input wire logic tdo,
	input wire logic tdo_oe,
	// register port
	input wire logic [AW-1:0] addr,
	input wire logic wr,
	// debug access
	input wire logic dbg_req,
	input wire logic dbg_done,
	input wire logic dbg_rnw,
	input wire logic [1:0] dbg_addr,
	// state
	input wire logic [4:0] pin_alt_function_select,
	input wire logic swd_mode,
	input wire logic flash_mass_erase,
	input wire logic [3:0] cur_instr
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	property p_pin_sysrst;
		!sys_rst_n [*5] |-> pin_alt_function_select == 5'h1f;
	endproperty
	a_pin_sysrst: assert property (p_pin_sysrst) else $error("pins not restored");
	property p_trst;
		!trst_n [*5] |-> cur_instr == 4'he && !tdo_oe;
	endproperty
	a_trst: assert property (p_trst) else $error("test reset not held");
	property p_tck_still;
		(trst_n && $stable(tck)) [*6] |=> $stable(cur_instr) && $stable(tdo) && $stable(tdo_oe);
	endproperty
	a_tck_still: assert property (p_tck_still) else $error("change without test clock");
	property p_tdo_chg;
		$changed(tdo) |-> !tck;
	endproperty
	a_tdo_chg: assert property (p_tdo_chg) else $error("data out moved while clock high");
	property p_oe_rise;
		$rose(tdo_oe) |-> !tck;
	endproperty
	a_oe_rise: assert property (p_oe_rise) else $error("enable rose while clock high");
	property p_swd_oe;
		swd_mode |-> !tdo_oe;
	endproperty
	a_swd_oe: assert property (p_swd_oe) else $error("data out driven in serial wire mode");
	property p_afsel;
		$changed(pin_alt_function_select) |-> $past(wr && addr == {AW{1'b0}}) || !$past(sys_rst_n, 2)
			|| !$past(sys_rst_n, 3) || !$past(sys_rst_n, 4);
	endproperty
	a_afsel: assert property (p_afsel) else $error("function select changed unasked");
	property p_erase;
		flash_mass_erase |-> !sys_rst_n ##1 !flash_mass_erase;
	endproperty
	a_erase: assert property (p_erase) else $error("bad erase pulse");
	property p_dbg_hold;
		dbg_req && !dbg_done && trst_n && cur_instr != 4'h8 |=> dbg_req && $stable(dbg_addr) && $stable(dbg_rnw);
	endproperty
	a_dbg_hold: assert property (p_dbg_hold) else $error("debug request dropped");
	property p_dbg_rise;
		$rose(dbg_req) |-> tck;
	endproperty
	a_dbg_rise: assert property (p_dbg_rise) else $error("request off test clock");
	c_dbg: cover property ($rose(dbg_req));
	c_swd: cover property ($rose(swd_mode));
	c_erase: cover property (flash_mass_erase);
endmodule
bind jtag_tap_debug_port jtag_tap_debug_port_asserts #(.AW(AW)) i_asserts (.clk(clk), .arst_n(arst_n),
	.tck(tck), .trst_n(trst_n), .sys_rst_n(sys_rst_n), .tdo(tdo), .tdo_oe(tdo_oe), .addr(addr), .wr(wr),
	.dbg_req(dbg_req), .dbg_done(dbg_done), .dbg_rnw(dbg_rnw), .dbg_addr(dbg_addr),
	.pin_alt_function_select(pin_alt_function_select), .swd_mode(swd_mode),
	.flash_mass_erase(flash_mass_erase), .cur_instr(cur_instr));

// >>> verification/jtag_probe.sv
// probe model for the test port pins
`timescale 1ns/1ns
module jtag_probe (
	// test port pins
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic trst_n,
	input wire logic tdo,
	input wire logic tdo_oe
);
	logic oe;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
		trst_n = 1'b1;
		oe = 1'b0;
	end
	// levels change at the fall, data out taken before the rise
	task automatic step(input logic m, input logic d, output logic q);
		tms <= m;
		tdi <= d;
		#62;
		q = tdo_oe ? tdo : 1'b1;
		oe = tdo_oe;
		tck <= 1'b1;
		#63;
		tck <= 1'b0;
	endtask
	task automatic run_tms(input int n, input logic [15:0] pat);
		logic q;
		for (int i = 0; i < n; i++) step(pat[i % 16], 1'b1, q);
	endtask
	// shift n bits lsb first, the last one leaves the shift state
	task automatic scan(input int n, input logic [34:0] din, output logic [34:0] dout);
		logic q;
		dout = '0;
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
	endtask
endmodule

// >>> verification/tb.sv
// self-checking bench for the test access port block
`timescale 1ns/1ns
module tb;
	localparam logic [31:0] id_val = 32'h0a5c3e71; // arbitrary identity value
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic sys_rst_n = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic dbg_done = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] dbg_rdata = 32'h3c96a5f0;
	logic [4:0] dly = 5'h0;
	logic [34:0] d;
	logic [40:0] rows [18];
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	int n_erase = 0;
	wire tck, tms, tdi, trst_n, tdo, tdo_oe, dbg_req, dbg_ap, dbg_rnw, swd_mode, erase;
	wire [31:0] rdata, dbg_wdata;
	wire [1:0] dbg_addr;
	wire [4:0] afsel, den, pur;
	wire [3:0] cur_instr;
	jtag_tap_debug_port #(.IDCODE_VALUE(id_val), .AW(8)) i_jtag_tap_debug_port (.clk(clk), .arst_n(arst_n),
		.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .sys_rst_n(sys_rst_n),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dbg_req(dbg_req), .dbg_ap(dbg_ap),
		.dbg_rnw(dbg_rnw), .dbg_addr(dbg_addr), .dbg_wdata(dbg_wdata), .dbg_done(dbg_done),
		.dbg_rdata(dbg_rdata), .pin_alt_function_select(afsel), .pin_digital_enable(den),
		.pin_pullup_enable(pur), .swd_mode(swd_mode), .flash_mass_erase(erase), .cur_instr(cur_instr));
	jtag_probe i_jtag_probe (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe));
	always #2 clk = ~clk;
	// system side answers a debug request after thirty cycles
	always @(posedge clk) begin
		dly <= (dbg_req && !dbg_done) ? dly + 5'h1 : 5'h0;
		dbg_done <= dly == 5'h1d;
		n_erase <= n_erase + int'(erase);
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail++;
			test_done();
		end
	end
	task test_done;
		if (n_fail == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [34:0] got, input logic [34:0] exp);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		if (!w) chk(35'(rdata), 35'(v));
	endtask
	task ir_load(input logic [3:0] v);
		i_jtag_probe.run_tms(4, 16'h0003);
		i_jtag_probe.scan(4, 35'(v), d);
		chk(d, 35'h1);
		i_jtag_probe.run_tms(2, 16'h0001);
		chk(35'(cur_instr), 35'(v));
	endtask
	initial begin
		rows = '{{1'b0, 8'h00, 32'h1f}, {1'b0, 8'h04, 32'h1f}, {1'b0, 8'h08, 32'h1f}, {1'b0, 8'h0c, 32'h1},
			{1'b1, 8'h00, 32'h0}, {1'b0, 8'h00, 32'h1f}, {1'b1, 8'h10, 32'h3}, {1'b1, 8'h0c, 32'h1acce551},
			{1'b0, 8'h0c, 32'h0}, {1'b1, 8'h00, 32'h0}, {1'b0, 8'h00, 32'h1f}, {1'b1, 8'h10, 32'h3},
			{1'b1, 8'h00, 32'h0}, {1'b0, 8'h00, 32'h1c}, {1'b0, 8'h18, 32'h0}, {1'b1, 8'h04, 32'h0},
			{1'b0, 8'h04, 32'h0}, {1'b0, 8'h14, 32'he}};
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk(35'({afsel, den, pur, cur_instr, tdo_oe, swd_mode}), 35'h1ffff8);
		foreach (rows[i]) bus(rows[i][40], rows[i][39:32], rows[i][31:0]);
		i_jtag_probe.run_tms(6, 16'h001f);
		i_jtag_probe.run_tms(3, 16'h0001);
		i_jtag_probe.scan(32, 35'(id_val), d);
		chk(d, 35'(id_val));
		chk(35'(i_jtag_probe.oe), 35'h1);
		i_jtag_probe.run_tms(2, 16'h0001);
		chk(35'(tdo_oe), 35'h0);
		ir_load(4'ha);
		repeat (300) @(posedge clk);
		chk(35'(cur_instr), 35'ha);
		i_jtag_probe.run_tms(3, 16'h0001);
		i_jtag_probe.scan(35, {32'h5a5a0f0f, 2'h1, 1'b1}, d);
		i_jtag_probe.run_tms(2, 16'h0001);
		chk({dbg_req, dbg_ap, dbg_rnw, dbg_addr, dbg_wdata[29:0]}, {5'b10101, 30'h1a5a0f0f});
		chk(35'(dbg_wdata), 35'h5a5a0f0f);
		i_jtag_probe.run_tms(3, 16'h0001);
		i_jtag_probe.scan(35, 35'h1, d);
		chk(d, {dbg_rdata, 3'h2});
		i_jtag_probe.run_tms(5, 16'h0007);
		i_jtag_probe.run_tms(5, 16'hffff);
		chk(35'(cur_instr), 35'he);
		i_jtag_probe.run_tms(1, 16'h0000);
		ir_load(4'hf);
		@(posedge clk);
		i_jtag_probe.trst_n <= 1'b0;
		repeat (8) @(posedge clk);
		chk(35'(cur_instr), 35'he);
		i_jtag_probe.trst_n <= 1'b1;
		i_jtag_probe.run_tms(50, 16'hffff);
		i_jtag_probe.run_tms(16, 16'he79e);
		i_jtag_probe.run_tms(50, 16'hffff);
		chk(35'(swd_mode), 35'h1);
		i_jtag_probe.run_tms(50, 16'hffff);
		i_jtag_probe.run_tms(16, 16'he73c);
		i_jtag_probe.run_tms(5, 16'hffff);
		chk(35'(swd_mode), 35'h0);
		@(posedge clk);
		sys_rst_n <= 1'b0;
		repeat (6) @(posedge clk);
		#1;
		chk(35'({afsel, den, pur}), 35'h7fff);
		repeat (5) begin
			i_jtag_probe.run_tms(50, 16'hffff);
			i_jtag_probe.run_tms(16, 16'he79e);
			i_jtag_probe.run_tms(50, 16'hffff);
			i_jtag_probe.run_tms(16, 16'he73c);
		end
		repeat (10) @(posedge clk);
		chk(35'(n_erase), 35'h1);
		sys_rst_n <= 1'b1;
		test_done();
	end
endmodule
